// ===== src/ros_pkg.sv
package ros_pkg;

  // ----------------------------------------------------------------------
  // Register map and field layout
  // ----------------------------------------------------------------------
  localparam int          ROS_NUM_REGS    = 8;
  localparam int          ROS_NUM_PINS    = 16;
  localparam int          ROS_SEL_W       = 5;
  localparam int          ROS_NUM_FUNCS   = 32;
  localparam int          ROS_ADDR_W      = 6;
  localparam int          ROS_DATA_W      = 32;
  localparam int          ROS_REG_W       = 16;
  localparam logic [5:0]  ROS_OFS_PAIR0   = 6'h00;
  localparam logic [5:0]  ROS_OFS_LAST    = 6'h1C;
  localparam int          ROS_EVEN_LSB    = 0;
  localparam int          ROS_ODD_LSB     = 8;
  localparam logic [4:0]  ROS_SEL_RESET   = 5'h00;
  localparam logic [4:0]  ROS_SEL_DEFAULT = 5'h00;
  localparam logic [31:0] ROS_UNMAPPED_RD = 32'h0000_0000;
  localparam logic [1:0]  ROS_RESP_OK     = 2'h0;
  localparam logic [1:0]  ROS_RESP_DECERR = 2'h3;

  typedef logic [ROS_SEL_W-1:0] ros_sel_t;

  typedef enum logic [1:0] {
    ROS_IDLE = 2'b00,
    ROS_ANS  = 2'b01
  } ros_state_t;

endpackage

// ===== src/ros_sel_if.sv
`timescale 1ns/10ps
// Carries the selector fields from the register file to the pin crossbar.
interface ros_sel_if;
  import ros_pkg::*;
  ros_sel_t sel [ROS_NUM_PINS];
  modport regs (output sel);
  modport xbar (input sel);
endinterface

// ===== src/ros_pin_mux.sv
`timescale 1ns/10ps
// ------------------------------------------------------------------------
// One remappable pin output selector
// ------------------------------------------------------------------------
module ros_pin_mux
  import ros_pkg::*;
(
  input  wire logic                     clock,
  input  wire logic                     rst,
  input  wire logic                     clk_en,
  input  wire ros_pkg::ros_sel_t        sel,
  input  wire logic [ROS_NUM_FUNCS-1:0] func_out,
  input  wire logic [ROS_NUM_FUNCS-1:0] func_oe,
  input  wire logic                     port_out,
  input  wire logic                     port_oe,
  output logic                          pin_out,
  output logic                          pin_oe
);

  // Code zero hands the pin back to its default port logic.
  wire logic use_port = (sel == ROS_SEL_DEFAULT);
  wire logic nxt_out  = use_port ? port_out : func_out[sel];
  wire logic nxt_oe   = use_port ? port_oe : func_oe[sel];

  // Registered so the pad never sees decode glitches while software rewrites a selector.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end else if (clk_en) begin
      pin_out <= nxt_out;
      pin_oe  <= nxt_oe;
    end
  end

endmodule

// ===== src/ros_xbar.sv
`timescale 1ns/10ps
// ------------------------------------------------------------------------
// Pin crossbar: one selector per remappable pin
// ------------------------------------------------------------------------
module ros_xbar
  import ros_pkg::*;
(
  input  wire logic                     clock,
  input  wire logic                     rst,
  input  wire logic                     clk_en,
  ros_sel_if.xbar                       sif,
  input  wire logic [ROS_NUM_FUNCS-1:0] func_out,
  input  wire logic [ROS_NUM_FUNCS-1:0] func_oe,
  input  wire logic [ROS_NUM_PINS-1:0]  port_out,
  input  wire logic [ROS_NUM_PINS-1:0]  port_oe,
  output logic      [ROS_NUM_PINS-1:0]  pin_out,
  output logic      [ROS_NUM_PINS-1:0]  pin_oe
);

  // Each pin picks its own function; the table lives in the register file, in pin order.
  for (genvar p = 0; p < ROS_NUM_PINS; p++) begin : g_pin
    ros_pin_mux u_mux (
      .clock    (clock),
      .rst      (rst),
      .clk_en   (clk_en),
      .sel      (sif.sel[p]),
      .func_out (func_out),
      .func_oe  (func_oe),
      .port_out (port_out[p]),
      .port_oe  (port_oe[p]),
      .pin_out  (pin_out[p]),
      .pin_oe   (pin_oe[p])
    );
  end

endmodule

// ===== src/ros_top.sv
`timescale 1ns/10ps
module ros_top
  import ros_pkg::*;
(
  input  wire logic                     clock,
  input  wire logic                     rst,
  input  wire logic                     clk_en,
  input  wire logic [ROS_ADDR_W-1:0]    avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [ROS_DATA_W-1:0]    avs_writedata,
  input  wire logic [3:0]               avs_byteenable,
  output logic      [ROS_DATA_W-1:0]    avs_readdata,
  output logic      [1:0]               avs_response,
  output logic                          avs_waitrequest,
  input  wire logic [ROS_NUM_FUNCS-1:0] func_out,
  input  wire logic [ROS_NUM_FUNCS-1:0] func_oe,
  input  wire logic [ROS_NUM_PINS-1:0]  port_out,
  input  wire logic [ROS_NUM_PINS-1:0]  port_oe,
  output logic      [ROS_NUM_PINS-1:0]  pin_out,
  output logic      [ROS_NUM_PINS-1:0]  pin_oe
);
  import ros_pkg::*;

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  ros_sel_t   even_ff [ROS_NUM_REGS];
  ros_sel_t   odd_ff  [ROS_NUM_REGS];
  ros_state_t state_ff;
  logic [ROS_DATA_W-1:0] rdata_ff;
  logic [1:0]            resp_ff;
  ros_sel_if  sif ();

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  // Only word-aligned offsets up to the last pair register are mapped.
  wire logic       hit     = (avs_address[1:0] == 2'b00) && (avs_address <= ROS_OFS_LAST);
  wire logic [2:0] idx     = avs_address[4:2];
  wire logic       req     = (avs_read || avs_write) && (state_ff == ROS_IDLE);
  wire logic       wr_go   = req && avs_write && hit;
  wire logic       wr_even = wr_go && avs_byteenable[0];
  wire logic       wr_odd  = wr_go && avs_byteenable[1];

  // Unimplemented bits are stuffed with zeros around each field.
  wire logic [ROS_DATA_W-1:0] rd_word = {16'h0000, 3'h0, odd_ff[idx], 3'h0, even_ff[idx]};
  wire logic [ROS_DATA_W-1:0] nxt_rdata = hit ? rd_word : ROS_UNMAPPED_RD;
  wire logic [1:0]            nxt_resp  = hit ? ROS_RESP_OK : ROS_RESP_DECERR;

  // One wait cycle: the request is accepted, then answered from flops.
  assign avs_waitrequest = (avs_read || avs_write) && (state_ff == ROS_IDLE);
  assign avs_readdata    = rdata_ff;
  assign avs_response    = resp_ff;

  // ----------------------------------------------------------------------
  // Handshake state
  // ----------------------------------------------------------------------
  // Bus timing, one request at a time, is as follows.
  // The first enabled edge that sees read or write with the state idle takes the request.
  // The read word and the response load at that edge, and a write lands in its field.
  // In the following cycle the state is answering and waitrequest is low.
  // The master samples the answer at the second edge and may then release.
  // The answer state always falls back to idle after one enabled edge.
  // That keeps waitrequest from dropping twice for one request.
  // A low clock enable holds the state where it is and so stretches the wait.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_ff <= ROS_IDLE;
      rdata_ff <= ROS_UNMAPPED_RD;
      resp_ff  <= ROS_RESP_OK;
    end else if (clk_en) begin
      unique case (state_ff)
        ROS_IDLE: begin
          if (req) begin
            state_ff <= ROS_ANS;
            rdata_ff <= avs_read ? nxt_rdata : ROS_UNMAPPED_RD;
            resp_ff  <= nxt_resp;
          end
        end
        ROS_ANS: begin
          state_ff <= ROS_IDLE;
        end
        default: begin
          state_ff <= ROS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Selector registers
  // ----------------------------------------------------------------------
  // Byte enables let software retarget one pin of a pair without touching the other.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int r = 0; r < ROS_NUM_REGS; r++) begin
        even_ff[r] <= ROS_SEL_RESET;
        odd_ff[r]  <= ROS_SEL_RESET;
      end
    end else if (clk_en) begin
      if (wr_even) begin
        even_ff[idx] <= avs_writedata[ROS_EVEN_LSB +: ROS_SEL_W];
      end
      if (wr_odd) begin
        odd_ff[idx] <= avs_writedata[ROS_ODD_LSB +: ROS_SEL_W];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pair to pin fan-out
  // ----------------------------------------------------------------------
  // Register k drives pin 2k from its low field and 2k+1 from its high field.
  for (genvar k = 0; k < ROS_NUM_REGS; k++) begin : g_pair
    assign sif.sel[2*k]   = even_ff[k];
    assign sif.sel[2*k+1] = odd_ff[k];
  end

  ros_xbar u_xbar (
    .clock    (clock),
    .rst      (rst),
    .clk_en   (clk_en),
    .sif      (sif.xbar),
    .func_out (func_out),
    .func_oe  (func_oe),
    .port_out (port_out),
    .port_oe  (port_oe),
    .pin_out  (pin_out),
    .pin_oe   (pin_oe)
  );

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // The taken step of a request; the store, read-back, miss no-write and hit/miss response checks below start from one of these.
  sequence s_wr_even;
    clk_en && wr_even;
  endsequence

  sequence s_wr_odd;
    clk_en && wr_odd;
  endsequence

  sequence s_rd_hit;
    clk_en && req && avs_read && hit;
  endsequence

  sequence s_req_hit;
    clk_en && req && hit;
  endsequence

  sequence s_req_miss;
    clk_en && req && !hit;
  endsequence

  sequence s_wr_miss;
    clk_en && req && avs_write && !hit;
  endsequence

  // ----------------------------------------------------------------------
  // Field storage checks
  // ----------------------------------------------------------------------
  // A lane that is written lands in its own field and nowhere else.
  AST_ODD_STORE: assert property (@(posedge clock) disable iff (rst)
    s_wr_odd |=> odd_ff[$past(idx)] == $past(avs_writedata[12:8]))
    else $error("odd field not stored");

  AST_EVEN_STORE: assert property (@(posedge clock) disable iff (rst)
    s_wr_even |=> even_ff[$past(idx)] == $past(avs_writedata[4:0]))
    else $error("even field not stored");

  // A lane that is left out keeps the other pin of the pair where it was.
  AST_KEEP_ODD: assert property (@(posedge clock) disable iff (rst)
    (clk_en && wr_go && !avs_byteenable[1]) |=> odd_ff[$past(idx)] == $past(odd_ff[idx]))
    else $error("odd field changed without its lane");

  AST_KEEP_EVEN: assert property (@(posedge clock) disable iff (rst)
    (clk_en && wr_go && !avs_byteenable[0]) |=> even_ff[$past(idx)] == $past(even_ff[idx]))
    else $error("even field changed without its lane");

  // With no write taken, even_ff[2] and odd_ff[5] stay put however long software waits.
  AST_STORE_HOLD: assert property (@(posedge clock) disable iff (rst)
    !(clk_en && wr_go) |=> $stable(even_ff[2]) && $stable(odd_ff[5]))
    else $error("selector changed without a write");

  // A refused write must not spill into the register that its middle address bits alias.
  AST_MISS_NO_WRITE: assert property (@(posedge clock) disable iff (rst)
    s_wr_miss |=> even_ff[$past(idx)] == $past(even_ff[idx])
                  && odd_ff[$past(idx)] == $past(odd_ff[idx]))
    else $error("unmapped write reached a register");

  // ----------------------------------------------------------------------
  // Pair to pin checks
  // ----------------------------------------------------------------------
  AST_PAIR_MAP: assert property (@(posedge clock) disable iff (rst)
    sif.sel[7] == odd_ff[3] && sif.sel[14] == even_ff[7])
    else $error("pair to pin mapping wrong");

  // Pins follow their function one enabled edge after the selector says so.
  AST_PIN_ROUTE: assert property (@(posedge clock) disable iff (rst)
    (clk_en && sif.sel[0] != 5'h00) |=> pin_out[0] == $past(func_out[sif.sel[0]]))
    else $error("pin 0 not driven by selected function");

  AST_PIN_ROUTE_ODD: assert property (@(posedge clock) disable iff (rst)
    (clk_en && sif.sel[15] != 5'h00) |=> pin_oe[15] == $past(func_oe[sif.sel[15]]))
    else $error("pin 15 enable not taken from selected function");

  // Code zero gives the pin back to the port logic, drive and enable alike.
  AST_PIN_PORT: assert property (@(posedge clock) disable iff (rst)
    (clk_en && sif.sel[1] == 5'h00) |=> pin_oe[1] == $past(port_oe[1]))
    else $error("code zero does not select port logic");

  AST_PIN_PORT_EVEN: assert property (@(posedge clock) disable iff (rst)
    (clk_en && sif.sel[14] == 5'h00) |=> pin_out[14] == $past(port_out[14]))
    else $error("pin 14 does not follow port logic at code zero");

  // ----------------------------------------------------------------------
  // Bus answer checks
  // ----------------------------------------------------------------------
  // Unimplemented bits are zero in every answer, whatever the request was.
  AST_HIGH_ZERO: assert property (@(posedge clock) disable iff (rst)
    (state_ff == ROS_ANS) |-> avs_readdata[15:13] == 3'h0)
    else $error("bits 15..13 not zero");

  AST_MID_ZERO: assert property (@(posedge clock) disable iff (rst)
    (state_ff == ROS_ANS) |-> avs_readdata[7:5] == 3'h0)
    else $error("bits 7..5 not zero");

  AST_UPPER_HALF_ZERO: assert property (@(posedge clock) disable iff (rst)
    (state_ff == ROS_ANS) |-> avs_readdata[31:16] == 16'h0000)
    else $error("upper half of read data not zero");

  // Read data carries both stored fields of the addressed pair.
  AST_READ_BACK: assert property (@(posedge clock) disable iff (rst)
    s_rd_hit |=> avs_readdata[4:0] == even_ff[$past(idx)])
    else $error("read data differs from stored field");

  AST_ODD_READ_BACK: assert property (@(posedge clock) disable iff (rst)
    s_rd_hit |=> avs_readdata[12:8] == odd_ff[$past(idx)])
    else $error("read data differs from stored odd field");

  // Mapped requests answer OK; anything else answers a decode error and zero data.
  AST_HIT_RESP: assert property (@(posedge clock) disable iff (rst)
    s_req_hit |=> avs_response == ROS_RESP_OK)
    else $error("mapped request not answered OK");

  AST_MISS_RESP: assert property (@(posedge clock) disable iff (rst)
    s_req_miss |=> avs_response == ROS_RESP_DECERR && avs_readdata == ROS_UNMAPPED_RD)
    else $error("unmapped request not refused");

  // Byte addresses between the word offsets are refused, not rounded down.
  AST_WORD_ALIGN: assert property (@(posedge clock) disable iff (rst)
    (clk_en && req && avs_address[1:0] != 2'b00) |=> avs_response == ROS_RESP_DECERR)
    else $error("unaligned request not refused");

  // The answer stands until the next request is taken, so a slow master still sees it.
  AST_ANSWER_HOLD: assert property (@(posedge clock) disable iff (rst)
    !(clk_en && req) |=> $stable(avs_readdata) && $stable(avs_response))
    else $error("answer changed without a new request");

  // ----------------------------------------------------------------------
  // Handshake checks
  // ----------------------------------------------------------------------
  // Exactly one wait cycle per request while the clock enable stays high, and none while the bus is quiet.
  AST_ONE_WAIT: assert property (@(posedge clock) disable iff (rst)
    (clk_en && req) |=> !avs_waitrequest)
    else $error("waitrequest held more than one cycle");

  AST_ANS_ONE: assert property (@(posedge clock) disable iff (rst)
    (clk_en && state_ff == ROS_ANS) |=> state_ff == ROS_IDLE)
    else $error("answer state held more than one cycle");

  AST_IDLE_NO_WAIT: assert property (@(posedge clock) disable iff (rst)
    (!avs_read && !avs_write) |-> !avs_waitrequest)
    else $error("waitrequest raised with no request");

  // ----------------------------------------------------------------------
  // Reset and clock enable checks
  // ----------------------------------------------------------------------
  // Sampled at the first edge after release, before any request can land.
  AST_RESET_CLEAR: assert property (@(posedge clock)
    $fell(rst) |-> even_ff[0] == 5'h00 && odd_ff[7] == 5'h00)
    else $error("selectors not cleared by reset");

  AST_RESET_PINS: assert property (@(posedge clock)
    $fell(rst) |-> pin_out == 16'h0000 && pin_oe == 16'h0000)
    else $error("pins not idle after reset");

  AST_RESET_IDLE: assert property (@(posedge clock)
    $fell(rst) |-> state_ff == ROS_IDLE && avs_readdata == ROS_UNMAPPED_RD
                   && avs_response == ROS_RESP_OK)
    else $error("bus side not idle after reset");

  // A low enable freezes every flop, the handshake and the pads included.
  AST_FREEZE: assert property (@(posedge clock) disable iff (rst)
    !clk_en |=> $stable(state_ff) && $stable(pin_out) && $stable(pin_oe)
                && $stable(avs_readdata))
    else $error("state moved while clock enable was low");

endmodule

// ===== test/ros_periph_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------------------
// Peripheral function outputs and default port drive
// ------------------------------------------------------------------------
module ros_periph_model (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        step,
  output logic      [31:0] func_out,
  output logic      [31:0] func_oe,
  output logic      [15:0] port_out,
  output logic      [15:0] port_oe
);
  // Uneven seeds so that a wrong selector index lands on a different bit.
  // Values move only on step, which lets the bench see the pins follow.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      func_out <= 32'h9B3C_E1A5;
      func_oe  <= 32'h6D2B_74C8;
      port_out <= 16'hC3A5;
      port_oe  <= 16'h5A96;
    end else if (step) begin
      func_out <= {func_out[0], func_out[31:1]};
      func_oe  <= ~func_oe;
      port_out <= ~port_out;
      port_oe  <= {port_oe[14:0], port_oe[15]};
    end
  end
endmodule

// ===== test/tb_ros_top.sv
`timescale 1ns/10ps
module tb_ros_top;
  import ros_pkg::*;
  logic        clock = 1'b0;
  logic        rst   = 1'b1;
  logic        clk_en = 1'b1;
  logic        step  = 1'b0;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [31:0] avs_readdata, func_out, func_oe;
  logic [1:0]  avs_response;
  logic        avs_waitrequest;
  logic [15:0] port_out, port_oe, pin_out, pin_oe;
  int          err_count = 0;
  int          checks_done = 0;

  always #5 clock = ~clock;

  ros_periph_model ros_periph_model_i (.clock(clock), .rst(rst), .step(step),
    .func_out(func_out), .func_oe(func_oe), .port_out(port_out), .port_oe(port_oe));
  ros_top ros_top_i (.clock(clock), .rst(rst), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_response(avs_response),
    .avs_waitrequest(avs_waitrequest), .func_out(func_out), .func_oe(func_oe),
    .port_out(port_out), .port_oe(port_oe), .pin_out(pin_out), .pin_oe(pin_oe));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic end_of_test();
    if (err_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One bus cycle, entered just after a rising edge; a spare edge at the end
  // keeps a following request from being raised in the release time step.
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q, output logic [1:0] r);
    int n;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      err_count++;
      end_of_test();
    end
    q = avs_readdata;
    r = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic reset_values();
    logic [31:0] q;
    logic [1:0]  r;
    for (int k = 0; k < 8; k++) begin
      bus(1'b0, 6'(4 * k), 32'h0, 4'hF, q, r);
      chk(q, 32'h0000_0000);
    end
  endtask

  // All ones must read back only the selector bits; a single lane keeps the other.
  task automatic reg_access();
    logic [31:0] q;
    logic [1:0]  r;
    for (int k = 0; k < 8; k++) begin
      bus(1'b1, 6'(4 * k), 32'hFFFF_FFFF, 4'hF, q, r);
      bus(1'b0, 6'(4 * k), 32'h0, 4'hF, q, r);
      chk(q, 32'h0000_1F1F);
      bus(1'b1, 6'(4 * k), 32'h0, 4'h2, q, r);
      bus(1'b0, 6'(4 * k), 32'h0, 4'hF, q, r);
      chk(q, 32'h0000_001F);
      bus(1'b1, 6'(4 * k), 32'h0000_1F0A, 4'h1, q, r);
      bus(1'b0, 6'(4 * k), 32'h0, 4'hF, q, r);
      chk(q, 32'h0000_000A);
    end
  endtask

  task automatic unmapped();
    logic [31:0] q;
    logic [1:0]  r;
    bus(1'b0, 6'h20, 32'h0, 4'hF, q, r);
    chk({q[29:0], r}, {30'h0, ROS_RESP_DECERR});
    bus(1'b0, 6'h02, 32'h0, 4'hF, q, r);
    chk({q[29:0], r}, {30'h0, ROS_RESP_DECERR});
    // Offset 0x20 aliases pair 0 in its middle bits, so a leak would show there.
    bus(1'b1, 6'h20, 32'hFFFF_FFFF, 4'hF, q, r);
    chk({q[29:0], r}, {30'h0, ROS_RESP_DECERR});
    bus(1'b0, 6'h00, 32'h0, 4'hF, q, r);
    chk(q, 32'h0000_000A);
  endtask

  // A low enable must hold the pins while the functions keep moving under them.
  task automatic freeze();
    logic [31:0] held;
    @(posedge clock);
    clk_en <= 1'b0;
    #1;
    held = {pin_oe, pin_out};
    step = 1'b1;
    repeat (3) @(posedge clock);
    #1;
    step = 1'b0;
    chk({pin_oe, pin_out}, held);
    @(posedge clock);
    clk_en <= 1'b1;
    @(posedge clock);
    #1;
    chk({pin_oe, pin_out}, {func_oe[31:16], func_out[31:16]});
  endtask

  // Pin p gets code p + 16 * j, so two passes visit every code, zero included.
  task automatic pin_map(input int j);
    logic [31:0] q;
    logic [1:0]  r;
    logic [4:0]  c;
    logic [15:0] eo, ee;
    for (int k = 0; k < 8; k++) begin
      bus(1'b1, 6'(4 * k), {19'h0, 5'(2 * k + 1 + 16 * j), 3'h0, 5'(2 * k + 16 * j)},
          4'hF, q, r);
    end
    for (int s = 0; s < 2; s++) begin
      @(posedge clock);
      #1;
      for (int p = 0; p < 16; p++) begin
        c = 5'(p + 16 * j);
        ee[p] = (c == 5'h00) ? port_out[p] : func_out[c];
        eo[p] = (c == 5'h00) ? port_oe[p] : func_oe[c];
      end
      chk({pin_oe, pin_out}, {eo, ee});
      step = 1'b1;
      @(posedge clock);
      #1;
      step = 1'b0;
      @(posedge clock);
    end
  endtask

  // ----------------------------------------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    reset_values();
    reg_access();
    unmapped();
    pin_map(0);
    pin_map(1);
    freeze();
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    end_of_test();
  end
endmodule
